/* File: include/ccr_pkg.sv */
// package: register map, field positions and carrier types for the comparator control bank
package ccr_pkg;

    // register indices; byte address is four times the index
    localparam logic [3:0] CCR_IDX_CS  = 4'h0;
    localparam logic [3:0] CCR_IDX_SEL = 4'h1;
    localparam logic [3:0] CCR_IDX_DAC = 4'h2;
    localparam logic [3:0] CCR_IDX_PIN = 4'h3;

    // control-status fields
    localparam int CCR_CS_ENABLE = 7;
    localparam int CCR_CS_HYST   = 6;
    localparam int CCR_CS_FLAG   = 5;
    localparam int CCR_CS_IRQEN  = 4;
    localparam int CCR_CS_OUT    = 3;
    localparam int CCR_CS_PINEN  = 2;
    localparam int CCR_CS_MODE_L = 0;

    // input-select fields
    localparam int CCR_SEL_POS_L = 4;
    localparam int CCR_SEL_NEG_L = 0;

    // ladder fields
    localparam int CCR_DAC_EN    = 7;
    localparam int CCR_DAC_SRC   = 6;
    localparam int CCR_DAC_LVL_L = 0;

    // reset values
    localparam logic [7:0] CCR_CS_RESET  = 8'h00;
    localparam logic [7:0] CCR_SEL_RESET = 8'h00;
    localparam logic [7:0] CCR_DAC_RESET = 8'h00;
    localparam logic [2:0] CCR_PIN_RESET = 3'h0;

    // edge-sensitivity codes
    localparam logic [1:0] CCR_MODE_FALL0 = 2'h0;
    localparam logic [1:0] CCR_MODE_RISE  = 2'h1;
    localparam logic [1:0] CCR_MODE_FALL2 = 2'h2;
    localparam logic [1:0] CCR_MODE_BOTH  = 2'h3;

    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } ccr_wb_req_t;

    typedef struct packed {
        logic [31:0] dat;
        logic        ack;
    } ccr_wb_rsp_t;

    typedef struct packed {
        logic       comparatorEnable;
        logic       hysteresisSelect;
        logic [1:0] positiveInputSelect;
        logic [1:0] negativeInputSelect;
        logic       outputPinEnable;
        logic       ladderEnable;
        logic       ladderSourceSelect;
        logic [5:0] ladderLevel;
        logic [2:0] externalInputAllow;
    } ccr_analog_t;

    typedef struct packed {
        logic       comparatorEnable;
        logic       hysteresisSelect;
        logic       edgeFlag;
        logic       edgeIrqEnable;
        logic       outputPinEnable;
        logic [1:0] edgeSensitivity;
        logic [1:0] positiveInputSelect;
        logic [1:0] negativeInputSelect;
        logic [7:0] ladder;
        logic [2:0] inputAllow;
        logic       sync1;
        logic       sync2;
        logic       syncPrev;
        logic       pinOut;
        logic       irq;
        logic       ack;
        logic [31:0] rdat;
    } ccr_state_t;

endpackage

/* File: rtl/ccr_comparator_control_regs.sv */
// comparator control register bank with synchronised output, edge flag and interrupt
`timescale 1ns/1ps

module ccr_comparator_control_regs
(
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire ccr_pkg::ccr_wb_req_t wbReq,
    output      ccr_pkg::ccr_wb_rsp_t wbRsp,
    input  wire logic                 rawCompareOut,
    output      ccr_pkg::ccr_analog_t analogCtrl,
    output logic                      comparePadOut,
    output logic                      edgeIrq
);
    import ccr_pkg::*;

    ccr_state_t stateReg;
    ccr_state_t stateNext;

    logic       access;
    logic       wrLow;
    logic [3:0] index;
    logic       rise;
    logic       fall;
    logic       edgeHit;
    logic [7:0] csRead;

    always_comb
    begin
        stateNext = stateReg;
        index     = wbReq.adr[5:2];
        // a new access is taken only when ack is low, so each gets one ack pulse
        access    = wbReq.cyc && wbReq.stb && !stateReg.ack;
        wrLow     = access && wbReq.we && wbReq.sel[0] && (wbReq.adr[31:6] == 26'h0);

        // the second stage is the only reader of the first
        stateNext.sync1    = rawCompareOut;
        stateNext.sync2    = stateReg.sync1;
        // gating after the synchroniser keeps a disabled comparator reading 0
        stateNext.syncPrev = stateReg.sync2 && stateReg.comparatorEnable;
        rise = stateNext.syncPrev && !stateReg.syncPrev;
        fall = !stateNext.syncPrev && stateReg.syncPrev;

        case (stateReg.edgeSensitivity)
            CCR_MODE_FALL0: edgeHit = fall;
            CCR_MODE_RISE:  edgeHit = rise;
            CCR_MODE_FALL2: edgeHit = fall;
            CCR_MODE_BOTH:  edgeHit = rise || fall;
            default:        edgeHit = 1'b0;
        endcase

        csRead = {stateReg.comparatorEnable, stateReg.hysteresisSelect,
                  stateReg.edgeFlag, stateReg.edgeIrqEnable, stateReg.syncPrev,
                  stateReg.outputPinEnable, stateReg.edgeSensitivity};

        if (wrLow)
        begin
            case (index)
                CCR_IDX_CS:
                begin
                    stateNext.comparatorEnable = wbReq.dat[CCR_CS_ENABLE];
                    stateNext.hysteresisSelect = wbReq.dat[CCR_CS_HYST];
                    stateNext.edgeIrqEnable    = wbReq.dat[CCR_CS_IRQEN];
                    stateNext.outputPinEnable  = wbReq.dat[CCR_CS_PINEN];
                    stateNext.edgeSensitivity  = wbReq.dat[CCR_CS_MODE_L +: 2];
                    if (!wbReq.dat[CCR_CS_FLAG])
                    begin
                        stateNext.edgeFlag = 1'b0;
                    end
                end
                CCR_IDX_SEL:
                begin
                    stateNext.positiveInputSelect = wbReq.dat[CCR_SEL_POS_L +: 2];
                    stateNext.negativeInputSelect = wbReq.dat[CCR_SEL_NEG_L +: 2];
                end
                CCR_IDX_DAC:
                begin
                    stateNext.ladder = wbReq.dat[7:0];
                end
                CCR_IDX_PIN:
                begin
                    stateNext.inputAllow = wbReq.dat[2:0];
                end
                default:
                begin
                    stateNext.ladder = stateReg.ladder;
                end
            endcase
        end

        // set wins over a clearing write in the same cycle
        if (edgeHit)
        begin
            stateNext.edgeFlag = 1'b1;
        end

        stateNext.irq    = stateNext.edgeFlag && stateNext.edgeIrqEnable;
        stateNext.pinOut = stateNext.syncPrev && stateNext.outputPinEnable;
        stateNext.ack    = access;
        stateNext.rdat   = 32'h0;
        if (access && !wbReq.we && (wbReq.adr[31:6] == 26'h0))
        begin
            case (index)
                CCR_IDX_CS:  stateNext.rdat = {24'h0, csRead};
                CCR_IDX_SEL: stateNext.rdat = {26'h0, stateReg.positiveInputSelect,
                                               2'h0, stateReg.negativeInputSelect};
                CCR_IDX_DAC: stateNext.rdat = {24'h0, stateReg.ladder};
                CCR_IDX_PIN: stateNext.rdat = {29'h0, stateReg.inputAllow};
                default:     stateNext.rdat = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            // everything to defaults: comparator and ladder off
            stateReg                     <= '0;
            stateReg.comparatorEnable    <= CCR_CS_RESET[CCR_CS_ENABLE];
            stateReg.hysteresisSelect    <= CCR_CS_RESET[CCR_CS_HYST];
            stateReg.edgeFlag            <= CCR_CS_RESET[CCR_CS_FLAG];
            stateReg.edgeIrqEnable       <= CCR_CS_RESET[CCR_CS_IRQEN];
            stateReg.outputPinEnable     <= CCR_CS_RESET[CCR_CS_PINEN];
            stateReg.edgeSensitivity     <= CCR_CS_RESET[CCR_CS_MODE_L +: 2];
            stateReg.positiveInputSelect <= CCR_SEL_RESET[CCR_SEL_POS_L +: 2];
            stateReg.negativeInputSelect <= CCR_SEL_RESET[CCR_SEL_NEG_L +: 2];
            stateReg.ladder              <= CCR_DAC_RESET;
            stateReg.inputAllow          <= CCR_PIN_RESET;
            stateReg.syncPrev            <= 1'b0;
        end
        else
        begin
            stateReg <= stateNext;
        end
    end

    assign wbRsp.ack = stateReg.ack;
    assign wbRsp.dat = stateReg.rdat;
    assign comparePadOut = stateReg.pinOut;
    assign edgeIrq       = stateReg.irq;

    assign analogCtrl.comparatorEnable    = stateReg.comparatorEnable;
    assign analogCtrl.hysteresisSelect    = stateReg.hysteresisSelect;
    assign analogCtrl.positiveInputSelect = stateReg.positiveInputSelect;
    assign analogCtrl.negativeInputSelect = stateReg.negativeInputSelect;
    assign analogCtrl.outputPinEnable     = stateReg.outputPinEnable;
    assign analogCtrl.ladderEnable        = stateReg.ladder[CCR_DAC_EN];
    assign analogCtrl.ladderSourceSelect  = stateReg.ladder[CCR_DAC_SRC];
    assign analogCtrl.ladderLevel         = stateReg.ladder[CCR_DAC_LVL_L +: 6];
    assign analogCtrl.externalInputAllow  = stateReg.inputAllow;

endmodule

/* File: test/ccr_checker_sva.sv */
// concurrent checks on the comparator control bank ports
`timescale 1ns/1ps

module ccr_checker
(
    input wire logic                 clock,
    input wire logic                 rst_n,
    input wire ccr_pkg::ccr_wb_req_t wbReq,
    input wire ccr_pkg::ccr_wb_rsp_t wbRsp,
    input wire logic                 rawCompareOut,
    input wire ccr_pkg::ccr_analog_t analogCtrl,
    input wire logic                 comparePadOut,
    input wire logic                 edgeIrq
);
    import ccr_pkg::*;
    logic go;
    logic csWr;
    assign go = wbReq.cyc && wbReq.stb && !wbRsp.ack;
    // the two low address bits are ignored by the bank, so any byte of word 0 writes it
    assign csWr = go && wbReq.we && wbReq.sel[0] && wbReq.adr[31:2] == 30'h0;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence dacWrite;
        go && wbReq.we && wbReq.sel[0] && wbReq.adr[31:2] == 30'h2;
    endsequence
    sequence selRead;
        go && !wbReq.we && wbReq.adr[31:2] == 30'h1;
    endsequence
    AST_ACK_PULSE: assert property (go |=> wbRsp.ack ##1 !wbRsp.ack)
        else $error("ack not a one-cycle answer");
    AST_RSP_IDLE: assert property (!wbRsp.ack |-> wbRsp.dat == 32'h0)
        else $error("read data outside ack");
    AST_SEL_RSVD: assert property (selRead |=> (wbRsp.dat & 32'hFFFF_FFCC) == 32'h0)
        else $error("reserved select bits not zero");
    AST_CS_CFG: assert property (csWr |=> analogCtrl.comparatorEnable == $past(wbReq.dat[7])
        && analogCtrl.hysteresisSelect == $past(wbReq.dat[6]))
        else $error("enable or hysteresis not taken");
    AST_DAC_CFG: assert property (dacWrite |=> {analogCtrl.ladderEnable,
        analogCtrl.ladderSourceSelect, analogCtrl.ladderLevel} == $past(wbReq.dat[7:0]))
        else $error("ladder fields not taken");
    AST_OFF_QUIET: assert property (!analogCtrl.comparatorEnable |=> !comparePadOut)
        else $error("output while comparator off");
    // pad and pin enable are registered from the same next state, so they agree every cycle
    AST_PAD_GATE: assert property (!analogCtrl.outputPinEnable |-> !comparePadOut)
        else $error("pad driven without pin enable");
    AST_IRQ_HOLD: assert property (edgeIrq && !csWr |=> edgeIrq)
        else $error("interrupt dropped without clear");
    AST_IRQ_MASK: assert property (csWr && !wbReq.dat[4] |-> ##2 !edgeIrq)
        else $error("interrupt while disabled");
    // two sync flops plus the gated flop put the pad exactly three edges behind the raw input
    AST_PAD_LAT: assert property (comparePadOut |-> $past(rawCompareOut, 3))
        else $error("pad not following synchronised raw output");
endmodule

bind ccr_comparator_control_regs ccr_checker u_chk (.clock(clock), .rst_n(rst_n),
    .wbReq(wbReq), .wbRsp(wbRsp), .rawCompareOut(rawCompareOut), .analogCtrl(analogCtrl),
    .comparePadOut(comparePadOut), .edgeIrq(edgeIrq));

/* File: test/ccr_comparator_model.sv */
// behavioural comparator core driving the raw result
`timescale 1ns/1ps

module ccr_comparator_model
(
    input wire logic                 clock,
    input wire ccr_pkg::ccr_analog_t analogCtrl,
    input wire logic                 level,
    output logic                     rawCompareOut
);
    import ccr_pkg::*;
    logic junkReg = 1'b0;
    always_ff @(posedge clock)
    begin
        junkReg <= ~junkReg;
    end
    // a disabled core gives no defined result, so it toggles instead of holding
    assign rawCompareOut = analogCtrl.comparatorEnable ? level : junkReg;
endmodule

/* File: test/test_comparator_control_regs.sv */
// register-level bench for the comparator control bank
`timescale 1ns/1ps

module test_comparator_control_regs;
    import ccr_pkg::*;
    logic        clock;
    logic        rst_n;
    logic        level;
    logic        rawCompareOut;
    logic        comparePadOut;
    logic        edgeIrq;
    logic        f;
    ccr_wb_req_t wbReq;
    ccr_wb_rsp_t wbRsp;
    ccr_analog_t analogCtrl;
    int          errTotal;
    int          checks;
    int          cycles;

    ccr_comparator_control_regs u_dut (.clock(clock), .rst_n(rst_n), .wbReq(wbReq),
        .wbRsp(wbRsp), .rawCompareOut(rawCompareOut), .analogCtrl(analogCtrl),
        .comparePadOut(comparePadOut), .edgeIrq(edgeIrq));
    ccr_comparator_model u_core (.clock(clock), .analogCtrl(analogCtrl), .level(level),
        .rawCompareOut(rawCompareOut));

    task automatic report_and_stop();
        if (errTotal == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic xfer(input logic [3:0] idx, input logic we, input logic [7:0] d,
        output logic [31:0] q);
        @(posedge clock);
        wbReq <= '{adr: {26'h0, idx, 2'h0}, dat: {24'h0, d}, sel: 4'hF, we: we,
            cyc: 1'b1, stb: 1'b1};
        @(posedge clock);
        while (wbRsp.ack !== 1'b1)
            @(posedge clock);
        q = wbRsp.dat;
        wbReq.cyc <= 1'b0;
        wbReq.stb <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [31:0] q;
        xfer(idx, 1'b1, d, q);
    endtask

    task automatic rd(input logic [3:0] idx, input logic [31:0] exp, input string what);
        logic [31:0] q;
        xfer(idx, 1'b0, 8'h00, q);
        check(what, q, exp);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // the whole run needs well under a thousand cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errTotal++;
            report_and_stop();
        end
    end

    initial
    begin
        {rst_n, level, errTotal, checks, cycles} = '0;
        wbReq = '0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        rd(4'h0, 32'h00, "cs reset");
        rd(4'h2, 32'h00, "ladder reset");
        rd(4'h9, 32'h00, "unmapped");
        wr(4'h1, 8'hFF);
        rd(4'h1, 32'h33, "select reserved");
        wr(4'h2, 8'hC5);
        rd(4'h2, 32'hC5, "ladder");
        wr(4'h3, 8'h05);
        level <= 1'b1;
        wr(4'h0, 8'h04);
        check("analog", 32'(analogCtrl), {14'h0, 2'h0, 4'hF, 3'h7, 6'h05, 3'h5});
        repeat (8) @(posedge clock);
        rd(4'h0, 32'h04, "output while off");
        for (int m = 0; m < 4; m++)
        begin
            level <= 1'b0;
            wr(4'h0, 8'(8'hD4 | m));
            repeat (8) @(posedge clock);
            wr(4'h0, 8'(8'hD4 | m));
            f = 1'b0;
            for (int s = 1; s >= 0; s--)
            begin
                level <= 1'(s);
                repeat (8) @(posedge clock);
                f = f | ((s == 1) ? m[0] : (m != 1));
                rd(4'h0, 32'(8'hD4 | m | s * 8 | {f, 5'h0}), "edge flag");
                check("irq", 32'(edgeIrq), 32'(f));
                check("pad", 32'(comparePadOut), 32'(s));
            end
            wr(4'h0, 8'(8'hF4 | m));
            rd(4'h0, 32'(8'hD4 | m | {f, 5'h0}), "flag kept");
        end
        wr(4'h0, 8'h87);
        level <= 1'b1;
        repeat (8) @(posedge clock);
        check("irq masked", 32'(edgeIrq), 32'h0);
        rd(4'h0, 32'hAF, "flag masked");
        wr(4'h0, 8'h07);
        repeat (8) @(posedge clock);
        rd(4'h0, 32'h27, "disabled");
        check("pad off", 32'(comparePadOut), 32'h0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(4'h2, 32'h00, "ladder after reset");
        check("analog reset", 32'(analogCtrl), 32'h0);
        report_and_stop();
    end
endmodule
